// ===== design/blc_link_engine.sv
// link engine: exchange memory on ahb-lite, tx serializer, rx packer, radio control
//
// Summary of operation
// RL1 - transmit bit periods follow the selected rate of 1 Mbps, 2 Mbps, 500 kbps or 125 kbps; the receive path does not use the rate.
// RL2 - only channels 0 to 39 (37 data, 3 advertising) are accepted; others refuse a start.
// RL3 - the processor reaches the exchange memory as ahb master and this block serves it.
// RL4 - software fills exchange memory and the engine serializes it as a bit stream to the modem.
// RL5 - bytes from the modem are packed into words and stored in exchange memory.
// RL6 - the engine steps on an 8 MHz enable tick taken from the system clock.
// RL7 - direction finding is offered only with 2 us slots.
// RL8 - modem and radio receiver are switched on a warm-up time before reception.
// RL9 - the modem detects and tracks packets and hands their bytes to the engine.
// RL10 - after a complete packet the modem and receiver are switched off.
// RL11 - during reception the channel goes straight to the radio.
// RL12 - during transmission channel and transmit power go straight to the radio.
// RL13 - the modem only shapes the bit stream it receives from the engine.
// RL14 - bus and engine never write memory in the same cycle, and words are written whole.
`default_nettype none
module blc_link_engine
    import blc_pkg::*;
(
    input  wire logic                  i_clock,
    input  wire logic                  i_sys_rst,
    input  wire logic                  i_hsel,
    input  wire logic [31:0]           i_haddr,
    input  wire logic [1:0]            i_htrans,
    input  wire logic                  i_hwrite,
    input  wire logic [31:0]           i_hwdata,
    input  wire logic                  i_hready,
    output logic      [31:0]           o_hrdata,
    output logic                       o_hreadyout,
    output logic                       o_hresp,
    input  wire logic                  i_tx_start,
    input  wire logic                  i_rx_start,
    input  wire logic [1:0]            i_phy_rate,
    input  wire logic [CHAN_W-1:0]     i_channel,
    input  wire logic [7:0]            i_tx_power,
    input  wire logic [MEM_AW-1:0]     i_tx_base,
    input  wire logic [MEM_AW-1:0]     i_tx_words,
    input  wire logic [MEM_AW-1:0]     i_rx_base,
    input  wire logic                  i_df_enable,
    input  wire logic [3:0]            i_df_slot_us,
    input  wire logic [7:0]            i_rx_data,
    input  wire logic                  i_rx_valid,
    input  wire logic                  i_rx_last,
    output logic                       o_rx_ready,
    output logic                       o_tx_bit,
    output logic                       o_tx_bit_valid,
    output logic                       o_modem_en,
    output logic                       o_radio_rx_en,
    output logic                       o_radio_tx_en,
    output logic      [CHAN_W-1:0]     o_radio_channel,
    output logic      [7:0]            o_radio_power,
    output logic                       o_df_active,
    output logic                       o_busy,
    output logic                       o_rx_done
);
    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic [SYM_W-1:0] bit_ticks(input logic [1:0] rate);
        case (rate)
            BLC_RATE_2M:   bit_ticks = SYM_W'(LINK_HZ / RATE_2M_BPS);
            BLC_RATE_500K: bit_ticks = SYM_W'(LINK_HZ / RATE_500K_BPS);
            BLC_RATE_125K: bit_ticks = SYM_W'(LINK_HZ / RATE_125K_BPS);
            default:       bit_ticks = SYM_W'(LINK_HZ / RATE_1M_BPS);
        endcase
    endfunction : bit_ticks

    logic [31:0]        mem [MEM_WORDS];
    logic [TICK_W-1:0]  div;
    logic               tick;
    logic               ahb_wr;
    logic [MEM_AW-1:0]  ahb_idx;
    logic               ahb_take;
    logic               eng_wr;
    logic [MEM_AW-1:0]  eng_idx;
    logic [31:0]        eng_word, next_eng_word;

    // ------------------------------------------------------------------
    // 8 MHz enable; 50/8 is not whole, so the tick runs slightly fast
    // ------------------------------------------------------------------
    assign tick = (div == TICK_W'(LINK_DIV - 1)); // RL6
    always_ff @(posedge i_clock) begin
        if (i_sys_rst || tick) begin
            div <= '0;
        end else begin
            div <= div + 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // ahb-lite slave, zero wait states, always okay
    // ------------------------------------------------------------------
    assign ahb_take    = i_hsel && i_htrans[1] && i_hready; // RL3
    assign o_hreadyout = 1'b1;
    assign o_hresp     = 1'b0;
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            ahb_wr   <= 1'b0;
            ahb_idx  <= '0;
            o_hrdata <= '0;
        end else begin
            ahb_wr  <= ahb_take && i_hwrite;
            ahb_idx <= i_haddr[WORD_LSB +: MEM_AW];
            if (ahb_take && !i_hwrite) begin
                o_hrdata <= mem[i_haddr[WORD_LSB +: MEM_AW]];
            end
        end
    end
    // bus data phase owns the write port; the engine waits a tick
    always_ff @(posedge i_clock) begin
        if (ahb_wr) begin
            mem[ahb_idx] <= i_hwdata; // RL14
        end else if (eng_wr) begin
            mem[eng_idx] <= eng_word;
        end
    end

    // ------------------------------------------------------------------
    // two-entry receive buffer
    // ------------------------------------------------------------------
    logic [8:0] buf_q [2];
    logic [1:0] buf_cnt, next_buf_cnt;
    logic       buf_rd, next_buf_rd;
    logic       buf_wr, next_buf_wr;
    logic       pop;
    logic       push;
    assign o_rx_ready = (buf_cnt != 2'h2);
    assign push       = i_rx_valid && o_rx_ready; // RL9
    always_comb begin
        next_buf_cnt = buf_cnt + {1'b0, push} - {1'b0, pop};
        next_buf_rd  = buf_rd ^ pop;
        next_buf_wr  = buf_wr ^ push;
    end
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            buf_cnt <= '0;
            buf_rd  <= 1'b0;
            buf_wr  <= 1'b0;
        end else begin
            buf_cnt <= next_buf_cnt;
            buf_rd  <= next_buf_rd;
            buf_wr  <= next_buf_wr;
        end
        if (push) begin
            buf_q[buf_wr] <= {i_rx_last, i_rx_data};
        end
    end

    // ------------------------------------------------------------------
    // engine state machine
    // ------------------------------------------------------------------
    blc_state_t        state, next_state;
    logic [MEM_AW-1:0] ptr, next_ptr;
    logic [MEM_AW-1:0] left, next_left;
    logic [4:0]        bitn, next_bitn;
    logic [SYM_W-1:0]  sym, next_sym;
    logic [WARM_W-1:0] warm, next_warm;
    logic [1:0]        bcnt, next_bcnt;
    logic              pend, next_pend;
    logic              lastw, next_lastw;
    logic [1:0]        rate, next_rate;
    logic [CHAN_W-1:0] chan, next_chan;
    logic [7:0]        pwr, next_pwr;
    logic              df, next_df;
    logic              chan_ok;
    logic [8:0]        head;

    assign chan_ok = (i_channel < CHAN_W'(CHAN_COUNT)); // RL2
    assign head    = buf_q[buf_rd];
    assign eng_idx = ptr;
    assign pop     = (state == BLC_RX_RUN) && tick && (buf_cnt != 2'h0) && !pend;
    assign eng_wr  = (state == BLC_RX_RUN) && tick && pend && !ahb_wr; // RL14

    always_comb begin
        next_state = state;
        next_eng_word = eng_word;
        next_ptr = ptr;
        next_left = left;
        next_bitn = bitn;
        next_sym = sym;
        next_warm = warm;
        next_bcnt = bcnt;
        next_pend = pend;
        next_lastw = lastw;
        next_rate = rate;
        next_chan = chan;
        next_pwr = pwr;
        next_df = df;
        case (state)
            BLC_IDLE: begin
                if (i_tx_start && chan_ok && i_tx_words != '0) begin
                    next_state = BLC_TX_LOAD;
                    next_ptr   = i_tx_base;
                    next_left  = i_tx_words;
                end else if (i_rx_start && chan_ok) begin
                    next_state = BLC_RX_WARM; // RL8
                    next_ptr   = i_rx_base;
                    next_warm  = '0;
                    next_bcnt  = '0;
                    next_pend  = 1'b0;
                    next_lastw = 1'b0;
                    next_eng_word = '0;
                end
                if ((i_tx_start || i_rx_start) && chan_ok) begin
                    next_rate = i_phy_rate; // RL1
                    next_chan = i_channel; // RL11 RL12
                    next_pwr  = i_tx_power; // RL12
                    next_df   = i_df_enable && (i_df_slot_us == 4'(DF_SLOT_US)); // RL7
                end
            end
            BLC_TX_LOAD: begin
                if (tick && !ahb_wr) begin
                    next_eng_word = mem[ptr]; // RL4
                    next_bitn     = '0;
                    next_sym      = '0;
                    next_state    = BLC_TX_SHIFT;
                end
            end
            BLC_TX_SHIFT: begin
                if (tick) begin
                    next_sym = sym + 1'b1;
                    if (sym == bit_ticks(rate) - 1'b1) begin // RL1
                        next_sym      = '0;
                        next_eng_word = eng_word >> 1;
                        next_bitn     = bitn + 1'b1;
                        if (bitn == 5'h1F) begin
                            next_ptr  = ptr + 1'b1;
                            next_left = left - 1'b1;
                            next_state = (left == MEM_AW'(1)) ? BLC_IDLE : BLC_TX_LOAD;
                        end
                    end
                end
            end
            BLC_RX_WARM: begin
                if (tick) begin
                    next_warm = warm + 1'b1;
                    if (warm == WARM_W'(RX_WARM_TICKS - 1)) begin
                        next_state = BLC_RX_RUN;
                    end
                end
            end
            BLC_RX_RUN: begin
                if (pop) begin
                    next_eng_word[8*bcnt +: 8] = head[7:0]; // RL5
                    next_bcnt  = bcnt + 1'b1;
                    next_lastw = head[8];
                    if (bcnt == 2'(BYTES_PER_WORD - 1) || head[8]) begin
                        next_pend = 1'b1;
                    end
                end
                if (eng_wr) begin
                    next_pend     = 1'b0;
                    next_bcnt     = '0;
                    next_eng_word = '0;
                    next_ptr      = ptr + 1'b1;
                    if (lastw) begin
                        next_state = BLC_RX_DONE;
                    end
                end
            end
            BLC_RX_DONE: begin
                next_state = BLC_IDLE; // RL10
            end
            default: begin
                next_state = BLC_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            state <= BLC_IDLE;
            eng_word <= '0;
            ptr <= '0;
            left <= '0;
            bitn <= '0;
            sym <= '0;
            warm <= '0;
            bcnt <= '0;
            pend <= 1'b0;
            lastw <= 1'b0;
            rate <= BLC_RATE_1M;
            chan <= '0;
            pwr <= '0;
            df <= 1'b0;
        end else begin
            state <= next_state;
            eng_word <= next_eng_word;
            ptr <= next_ptr;
            left <= next_left;
            bitn <= next_bitn;
            sym <= next_sym;
            warm <= next_warm;
            bcnt <= next_bcnt;
            pend <= next_pend;
            lastw <= next_lastw;
            rate <= next_rate;
            chan <= next_chan;
            pwr <= next_pwr;
            df <= next_df;
        end
    end

    // ------------------------------------------------------------------
    // modem and radio side
    // ------------------------------------------------------------------
    assign o_tx_bit        = eng_word[0]; // RL13
    assign o_tx_bit_valid  = (state == BLC_TX_SHIFT);
    assign o_radio_tx_en   = (state == BLC_TX_LOAD) || (state == BLC_TX_SHIFT);
    assign o_radio_rx_en   = (state == BLC_RX_WARM) || (state == BLC_RX_RUN); // RL8 RL10
    assign o_modem_en      = o_radio_tx_en || o_radio_rx_en;
    assign o_radio_channel = chan;
    assign o_radio_power   = pwr;
    assign o_df_active     = df && o_modem_en;
    assign o_busy          = (state != BLC_IDLE);
    assign o_rx_done       = (state == BLC_RX_DONE);

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_sys_rst);
    a_chan_refused: assert property ((state == BLC_IDLE) && !chan_ok |=> state == BLC_IDLE) // RL2
        else $error("start taken with channel out of range");
    a_bus_okay: assert property (o_hreadyout && !o_hresp) // RL3
        else $error("bus slave not ready or in error");
    a_bit_hold: assert property ($rose(o_tx_bit_valid) |-> o_tx_bit_valid [*8]) // RL1
        else $error("transmit bit stream ended too early");
    a_df_slot: assert property ($rose(df) |-> $past(i_df_slot_us) == 4'(DF_SLOT_US)) // RL7
        else $error("direction finding armed with a slot other than 2 us");
    a_warm_first: assert property ($rose(o_radio_rx_en) |-> state == BLC_RX_WARM [*8]) // RL8
        else $error("receiver not warmed before packet handling");
    a_rx_off_done: assert property (o_rx_done |=> !o_radio_rx_en && !o_modem_en) // RL10
        else $error("receiver left on after completed packet");
    a_chan_direct: assert property (o_modem_en |=> $stable(o_radio_channel)) // RL11
        else $error("channel changed during a frame");
    a_tx_radio: assert property (o_tx_bit_valid |-> o_radio_tx_en && $stable(o_radio_power)) // RL12
        else $error("power changed while transmitting");
    a_mem_excl: assert property (eng_wr |-> !ahb_wr) // RL14
        else $error("bus and engine wrote memory together");
    a_buf_full: assert property (buf_cnt == 2'h2 |-> !o_rx_ready) // RL5
        else $error("receive buffer accepts while full");
    c_tx_frame: cover property (o_radio_tx_en ##1 !o_radio_tx_en);
    c_rx_frame: cover property (o_rx_done);
    c_buf_full: cover property (buf_cnt == 2'h2);
    c_df_frame: cover property (o_df_active);
endmodule : blc_link_engine
`default_nettype wire

// ===== design/blc_pkg.sv
// constants and types for the low-energy link engine with modem control
`default_nettype none
package blc_pkg;
    // ------------------------------------------------------------------
    // clocking
    // ------------------------------------------------------------------
    localparam int CLK_HZ        = 50_000_000;
    localparam int LINK_HZ       = 8_000_000;
    localparam int LINK_DIV      = CLK_HZ / LINK_HZ;
    localparam int TICK_W        = 3;
    // ------------------------------------------------------------------
    // phy rates and bit periods in link ticks
    // ------------------------------------------------------------------
    localparam int RATE_1M_BPS   = 1_000_000;
    localparam int RATE_2M_BPS   = 2_000_000;
    localparam int RATE_500K_BPS = 500_000;
    localparam int RATE_125K_BPS = 125_000;
    localparam int SYM_W         = 7;
    typedef enum logic [1:0] {
        BLC_RATE_1M   = 2'h0,
        BLC_RATE_2M   = 2'h1,
        BLC_RATE_500K = 2'h2,
        BLC_RATE_125K = 2'h3
    } blc_rate_t;
    // ------------------------------------------------------------------
    // channels, direction finding, receive warm-up
    // ------------------------------------------------------------------
    localparam int CHAN_COUNT    = 40;
    localparam int ADV_CHANNELS  = 3;
    localparam int DATA_CHANNELS = 37;
    localparam int CHAN_W        = 6;
    localparam int DF_SLOT_US    = 2;
    localparam int RX_WARM_US    = 40;
    localparam int RX_WARM_TICKS = RX_WARM_US * (LINK_HZ / 1_000_000);
    localparam int WARM_W        = 9;
    // ------------------------------------------------------------------
    // exchange memory
    // ------------------------------------------------------------------
    localparam int MEM_AW        = 6;
    localparam int MEM_WORDS     = 1 << MEM_AW;
    localparam int WORD_LSB      = 2;
    localparam int BYTES_PER_WORD = 4;
    typedef enum logic [5:0] {
        BLC_IDLE     = 6'h01,
        BLC_TX_LOAD  = 6'h02,
        BLC_TX_SHIFT = 6'h04,
        BLC_RX_WARM  = 6'h08,
        BLC_RX_RUN   = 6'h10,
        BLC_RX_DONE  = 6'h20
    } blc_state_t;
endpackage : blc_pkg
`default_nettype wire

// ===== tb/blc_modem_model.sv
// behavioural modem: captures the tx bit stream and offers rx bytes on valid/ready
`default_nettype none
module blc_modem_model
    import blc_pkg::*;
(
    input  wire logic       i_clock,
    input  wire logic       i_tx_bit,
    input  wire logic       i_tx_bit_valid,
    input  wire logic       i_rx_ready,
    input  wire logic [1:0] i_rate,
    output logic      [7:0] o_rx_data,
    output logic            o_rx_valid,
    output logic            o_rx_last
);
    timeunit 1ns;
    timeprecision 1ps;
    int   per;
    int   cnt;
    int   valid_cycles;
    int   stuck;
    logic bits[$];
    initial begin
        o_rx_data  = 8'h00;
        o_rx_valid = 1'b0;
        o_rx_last  = 1'b0;
        stuck      = 0;
        cnt        = 0;
    end
    always_comb begin
        per = LINK_DIV * ((i_rate == 2'h0) ? 8 : (i_rate == 2'h1) ? 4 : (i_rate == 2'h2) ? 16 : 64);
    end
    // ------------------------------------------------------------------
    // transmit capture
    // ------------------------------------------------------------------
    // sample mid-bit so the load gap between words cannot skew the count
    always @(posedge i_clock) begin
        if (i_tx_bit_valid) begin
            valid_cycles++;
            if (cnt % per == per / 2) begin
                bits.push_back(i_tx_bit);
            end
            cnt++;
        end else begin
            cnt = 0;
        end
    end
    // ------------------------------------------------------------------
    // receive byte stream
    // ------------------------------------------------------------------
    task automatic send(input logic [7:0] q[$], input bit slow);
        int t;
        foreach (q[k]) begin
            @(negedge i_clock);
            o_rx_data  = q[k];
            o_rx_valid = 1'b1;
            o_rx_last  = (k == q.size() - 1);
            t = 0;
            @(posedge i_clock);
            while (!i_rx_ready && t < 5000) begin
                t++;
                @(posedge i_clock);
            end
            if (t >= 5000) begin
                stuck = 1;
            end
            if (slow || k == q.size() - 1) begin
                @(negedge i_clock);
                o_rx_valid = 1'b0;
                o_rx_last  = 1'b0;
                // released data must not look like the last byte
                o_rx_data  = ~q[k];
                if (slow) begin
                    repeat (3) @(negedge i_clock);
                end
            end
        end
    endtask : send
endmodule : blc_modem_model
`default_nettype wire

// ===== tb/ble_link_controller_modem_tb_top.sv
// testbench for the link engine: bus access, tx stream, rx packing, radio control
`default_nettype none
module ble_link_controller_modem_tb_top
    import blc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock, sys_rst, hsel, hwrite, tx_start, rx_start, df_en, tx_bit, tx_vld, rx_ready;
    logic modem_en, rx_en, tx_en, df_act, busy, rx_done, hreadyout, hresp, rx_valid, rx_last;
    logic [31:0]        haddr, hwdata, hrdata, rd;
    logic [1:0]         htrans, rate;
    logic [CHAN_W-1:0]  chan, radio_chan;
    logic [7:0]         power, radio_power, rx_data;
    logic [MEM_AW-1:0]  tx_base, tx_words, rx_base;
    logic [3:0]         slot;
    logic [31:0]        mem [MEM_WORDS];
    int                 err_count, checked, seed;
    int                 ptk [4] = '{8, 4, 16, 64};

    blc_link_engine uut (.i_clock(clock), .i_sys_rst(sys_rst), .i_hsel(hsel), .i_haddr(haddr),
        .i_htrans(htrans), .i_hwrite(hwrite), .i_hwdata(hwdata), .i_hready(1'b1),
        .o_hrdata(hrdata), .o_hreadyout(hreadyout), .o_hresp(hresp), .i_tx_start(tx_start),
        .i_rx_start(rx_start), .i_phy_rate(rate), .i_channel(chan), .i_tx_power(power),
        .i_tx_base(tx_base), .i_tx_words(tx_words), .i_rx_base(rx_base), .i_df_enable(df_en),
        .i_df_slot_us(slot), .i_rx_data(rx_data), .i_rx_valid(rx_valid), .i_rx_last(rx_last),
        .o_rx_ready(rx_ready), .o_tx_bit(tx_bit), .o_tx_bit_valid(tx_vld), .o_modem_en(modem_en),
        .o_radio_rx_en(rx_en), .o_radio_tx_en(tx_en), .o_radio_channel(radio_chan),
        .o_radio_power(radio_power), .o_df_active(df_act), .o_busy(busy), .o_rx_done(rx_done));
    blc_modem_model modem (.i_clock(clock), .i_tx_bit(tx_bit), .i_tx_bit_valid(tx_vld),
        .i_rx_ready(rx_ready), .i_rate(rate), .o_rx_data(rx_data), .o_rx_valid(rx_valid),
        .o_rx_last(rx_last));

    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %0t %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask : chk
    task automatic complete_run;
        if (err_count == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : complete_run
    // single transfer: address phase, then data phase with no wait states
    task automatic bus(input logic w, input int idx, input logic [31:0] wd);
        @(negedge clock);
        hsel = 1'b1;
        haddr = {24'h000000, idx[5:0], 2'h0};
        htrans = 2'h2;
        hwrite = w;
        @(negedge clock);
        hsel = 1'b0;
        htrans = 2'h0;
        hwdata = wd;
        rd = hrdata;
    endtask : bus
    task automatic wait_flag(input int which);
        int t;
        t = 0;
        while ((which == 0 ? busy !== 1'b0 : rx_done !== 1'b1) && t < 20000) begin
            @(negedge clock);
            t++;
        end
        if (t >= 20000) begin
            chk(32'h0, 32'h1, "wait timed out");
            complete_run();
        end
    endtask : wait_flag
    // ------------------------------------------------------------------
    // transmit: one word count, rate and slot per call
    // ------------------------------------------------------------------
    task automatic run_tx(input int i);
        int n;
        logic eb[$];
        rate = i % 4;
        n = (i % 4 == 3) ? 1 : 1 + i % 3;
        tx_base = $unsigned($random(seed)) % (MEM_WORDS - n);
        for (int w = 0; w < n; w++) begin
            mem[tx_base + w] = $random(seed);
            bus(1'b1, tx_base + w, mem[tx_base + w]);
            for (int b = 0; b < 32; b++) eb.push_back(mem[tx_base + w][b]);
        end
        chan = (i == 0) ? 6'h27 : $unsigned($random(seed)) % CHAN_COUNT;
        power = $random(seed);
        slot = i;
        tx_words = n;
        modem.bits.delete();
        modem.valid_cycles = 0;
        @(negedge clock);
        tx_start = 1'b1;
        @(negedge clock);
        tx_start = 1'b0;
        rx_start = 1'b1;
        chk(tx_en, 1'b1, "tx enable");
        chk(modem_en, 1'b1, "modem enable");
        chk(radio_chan, chan, "tx channel");
        chk(radio_power, power, "tx power");
        chk(df_act, i == 2, "direction finding");
        @(negedge clock);
        rx_start = 1'b0;
        chk(rx_en, 1'b0, "start while busy");
        wait_flag(0);
        chk(tx_en, 1'b0, "tx enable after");
        chk(modem.bits.size(), n * 32, "bit count");
        foreach (eb[k]) chk(modem.bits[k], eb[k], "tx bit");
        chk(modem.valid_cycles, n * 32 * ptk[i % 4] * LINK_DIV, "bit period");
    endtask : run_tx
    // ------------------------------------------------------------------
    // receive: random byte count, word packing checked over the bus
    // ------------------------------------------------------------------
    task automatic run_rx(input bit slow);
        logic [7:0] q[$];
        logic [31:0] w;
        int n;
        n = 3 + $unsigned($random(seed)) % 9;
        for (int k = 0; k < n; k++) q.push_back($random(seed));
        rx_base = $unsigned($random(seed)) % 60;
        chan = $unsigned($random(seed)) % CHAN_COUNT;
        rate = $random(seed);
        @(negedge clock);
        rx_start = 1'b1;
        @(negedge clock);
        rx_start = 1'b0;
        chk(rx_en, 1'b1, "rx enable");
        chk(modem_en, 1'b1, "modem enable rx");
        chk(radio_chan, chan, "rx channel");
        fork
            modem.send(q, slow);
            begin
                repeat (400) @(negedge clock);
                chk(rx_ready, 1'b0, "buffer full in warm-up");
                wait_flag(1);
                @(negedge clock);
                chk(rx_en, 1'b0, "rx off after packet");
                chk(modem_en, 1'b0, "modem off after packet");
            end
        join
        chk(modem.stuck, 0, "byte never taken");
        for (int j = 0; j < (n + 3) / 4; j++) begin
            w = 32'h0;
            for (int b = 0; b < 4; b++) if (4 * j + b < n) w[8 * b +: 8] = q[4 * j + b];
            bus(1'b0, rx_base + j, 32'h0);
            bus(1'b0, rx_base + j, 32'h0);
            chk(rd, w, "rx word");
        end
    endtask : run_rx
    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        seed = 29198;
        {sys_rst, hsel, hwrite, tx_start, rx_start, df_en} = 6'h21;
        {haddr, hwdata, htrans, rate, chan, power, tx_base, tx_words, rx_base, slot} = '0;
        repeat (12) @(negedge clock);
        sys_rst = 1'b0;
        chk({busy, tx_en, rx_en, modem_en, rx_ready}, 5'h01, "reset levels");
        chk(hrdata, 32'h0, "reset read data");
        chk({hreadyout, hresp}, 2'h2, "bus ready and okay");
        for (int k = 0; k < MEM_WORDS; k++) begin
            mem[k] = $random(seed);
            bus(1'b1, k, mem[k]);
        end
        for (int k = 0; k < MEM_WORDS; k++) begin
            bus(1'b0, k, 32'h0);
            chk(rd, mem[k], "bus readback");
        end
        for (int k = 0; k < 3; k++) begin
            chan = (k == 1) ? 6'h00 : 6'h28;
            tx_words = (k == 1) ? 6'h00 : 6'h01;
            @(negedge clock);
            tx_start = (k < 2);
            rx_start = (k == 2);
            @(negedge clock);
            {tx_start, rx_start} = 2'h0;
            chk(busy, 1'b0, "refused start");
        end
        for (int i = 0; i < 16; i++) run_tx(i);
        run_rx(1'b0);
        run_rx(1'b1);
        complete_run();
    end
endmodule : ble_link_controller_modem_tb_top
`default_nettype wire
